// ==== dv/lcd_instruction_decoder_tb_top.sv ====
`timescale 1ns/10ps
module lcd_instruction_decoder_tb_top
	import lcdd_pkg::*;
();
	logic mclk, reset_n, reset_n_pin, chip_select_a, chip_select_b, duty_half;
	logic avs_read, avs_write, avs_waitrequest, panel_on;
	logic [1:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	lcdd_scan_s scan;
	logic [7:0] q;
	logic [7:0] bad [4] = '{8'h00, 8'h3D, 8'h80, 8'hB7};
	int mram [512];
	int col, page, start, latch, p, c, k;
	int cyc = 0;
	int error_cnt = 0;
	int checks = 0;
	bit on;

	lcdd_decoder dut (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .reset_n_pin(reset_n_pin), .chip_select_a(chip_select_a),
		.chip_select_b(chip_select_b), .duty_half(duty_half), .panel_on(panel_on), .scan(scan));
	lcdd_host u_host (.mclk(mclk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	// ****
	// tasks
	// ****
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	task automatic cmd(input logic [7:0] d);
		u_host.ready();
		u_host.xfer(ADDR_CMD, 1'b1, d, q);
		if (d[7:1] == OP_ONOFF)
			on = d[0];
		else if (d[7:6] == OP_COL)
			col = d[5:0];
		else if (d[7:3] == OP_PAGE)
			page = d[2:0];
		else if (d[7:6] == OP_START)
			start = d[5:0];
	endtask : cmd
	task automatic dwr(input logic [7:0] d);
		u_host.ready();
		u_host.xfer(ADDR_DATA, 1'b1, d, q);
		mram[page * 64 + col] = d;
		col = (col + 1) % 64;
	endtask : dwr
	task automatic drd();
		u_host.ready();
		u_host.xfer(ADDR_DATA, 1'b0, 8'h00, q);
		if (latch >= 0)
			check("data", q, latch);
		latch = mram[page * 64 + col];
		col = (col + 1) % 64;
	endtask : drd
	task automatic stat(input logic [7:0] e);
		u_host.xfer(ADDR_CMD, 1'b0, 8'h00, q);
		check("status", q, e);
	endtask : stat
	task automatic scan_chk(input int n);
		int line, b;
		repeat (8)
			@(posedge mclk);
		repeat (n)
		begin
			@(negedge mclk);
			line = (start + scan.row) % 64;
			b = mram[line / 8 * 64 + scan.col];
			if (b >= 0)
				check("dot", scan.dot, on & b[line % 8]);
			if (duty_half)
				check("row", scan.row > ROWS_HALF_LAST, 1'b0);
		end
		@(posedge mclk);
	endtask : scan_chk

	// ****
	// clock and timeout
	// ****
	initial
	begin
		mclk = 1'b0;
		forever
			#12.5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			error_cnt++;
			test_done();
		end
	end

	// ****
	// sequence
	// ****
	initial
	begin
		reset_n = 1'b0;
		reset_n_pin = 1'b1;
		chip_select_a = 1'b1;
		chip_select_b = 1'b1;
		duty_half = 1'b1;
		foreach (mram[i])
			mram[i] = -1;
		latch = -1;
		col = 0;
		page = 0;
		start = 0;
		on = 1'b0;
		k = $urandom(32'h2559);
		repeat (8)
			@(posedge mclk);
		reset_n <= 1'b1;
		u_host.xfer(ADDR_CMD, 1'b1, 8'h3F, q);
		stat(8'h90);
		u_host.ready();
		stat(8'h00);
		check("panel", panel_on, 1'b0);
		$display("test init done");
		cmd(8'h3F);
		stat(8'hA0);
		u_host.ready();
		stat(8'h20);
		check("panel", panel_on, 1'b1);
		cmd(8'h3E);
		u_host.ready();
		stat(8'h00);
		check("panel", panel_on, 1'b0);
		$display("test onoff done");
		for (k = 0; k < 3; k++)
		begin
			p = (k == 0) ? 0 : $urandom % 8;
			c = 60 + $urandom % 4;
			cmd({OP_PAGE, 3'(p)});
			cmd({OP_COL, 6'(c)});
			repeat (9)
				dwr(8'($urandom));
			cmd({OP_COL, 6'(c)});
			repeat (9)
				drd();
		end
		$display("test data done");
		cmd({OP_COL, 6'(c)});
		u_host.xfer(ADDR_CMD, 1'b1, {OP_COL, 6'h09}, q);
		foreach (bad[i])
			cmd(bad[i]);
		repeat (3)
			drd();
		$display("test ignore done");
		u_host.ready();
		chip_select_b <= 1'b0;
		u_host.xfer(ADDR_DATA, 1'b1, 8'hFF, q);
		u_host.xfer(ADDR_CMD, 1'b0, 8'h00, q);
		check("status", q, 8'h00);
		chip_select_b <= 1'b1;
		chip_select_a <= 1'b0;
		u_host.xfer(ADDR_CMD, 1'b1, {OP_COL, 6'h20}, q);
		u_host.xfer(ADDR_CMD, 1'b0, 8'h00, q);
		check("status", q, 8'h00);
		chip_select_a <= 1'b1;
		u_host.xfer(2'h2, 1'b1, 8'h3F, q);
		u_host.xfer(2'h3, 1'b0, 8'h00, q);
		check("unmapped", q, 8'h00);
		repeat (2)
			drd();
		$display("test select done");
		c = (p * 8 - $urandom % 4 + 64) % 64;
		cmd({OP_START, 6'(c)});
		cmd(8'h3F);
		scan_chk(9000);
		cmd(8'h3E);
		scan_chk(300);
		cmd(8'h3F);
		scan_chk(3000);
		duty_half <= 1'b0;
		scan_chk(2000);
		$display("test scan done");
		reset_n_pin <= 1'b0;
		repeat (4)
			@(posedge mclk);
		u_host.xfer(ADDR_CMD, 1'b0, 8'h00, q);
		check("status", q & 8'h30, 8'h10);
		check("panel", panel_on, 1'b0);
		reset_n_pin <= 1'b1;
		on = 1'b0;
		start = 0;
		cmd(8'h3F);
		scan_chk(1500);
		$display("test reset pin done");
		test_done();
	end
endmodule : lcd_instruction_decoder_tb_top

// ==== dv/lcdd_host.sv ====
`timescale 1ns/10ps
module lcdd_host
	import lcdd_pkg::*;
(
	// clock
	input wire logic mclk,
	// bus master
	output logic [1:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	initial
	begin
		avs_address = 2'h3;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h5A5A5A5A;
	end
	// ****
	// one bus cycle
	// ****
	task automatic xfer(input logic [1:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
		@(posedge mclk);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= {24'h000000, d};
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0)
			@(posedge mclk);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// idle bus shows no stale value
		avs_address <= ~a;
		avs_writedata <= ~{24'h000000, d};
	endtask : xfer
	task automatic ready();
		logic [7:0] s;
		int n;
		s = 8'hFF;
		n = 0;
		while ((s[7] | s[4]) && n < 200)
		begin
			xfer(ADDR_CMD, 1'b0, 8'h00, s);
			n++;
		end
	endtask : ready
endmodule : lcdd_host

// ==== pkg/lcdd_pkg.sv ====
package lcdd_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_NS = 25;
	// initialization time after the reset pin rises
	localparam int INIT_NS = 1000;
	localparam int INIT_CYC = (INIT_NS + CLK_NS - 1) / CLK_NS;
	// internal operation time after each accepted access
	localparam int BUSY_NS = 100;
	localparam int BUSY_CYC = (BUSY_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] INIT_CNT = CNT_W'(INIT_CYC);
	localparam logic [CNT_W-1:0] BUSY_CNT = CNT_W'(BUSY_CYC);
	localparam logic [CNT_W-1:0] CNT_LAST = 6'h01;
	localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
	// scan advances one dot every 4 clocks, when div reaches SCAN_DIV_LAST
	localparam logic [1:0] SCAN_DIV_LAST = 2'h3;

	// ************************************************************
	// bus map (word index), both index bits decoded, indexes 2 and 3 unmapped
	// ************************************************************
	localparam logic [1:0] ADDR_CMD = 2'h0;
	localparam logic [1:0] ADDR_DATA = 2'h1;

	// ************************************************************
	// instruction patterns
	// ************************************************************
	localparam logic [6:0] OP_ONOFF = 7'h1F;
	localparam logic [1:0] OP_COL = 2'h1;
	localparam logic [4:0] OP_PAGE = 5'h17;
	localparam logic [1:0] OP_START = 2'h3;

	// ************************************************************
	// status bit positions
	// ************************************************************
	localparam int ST_BUSY = 7;
	localparam int ST_ONOFF = 5;
	localparam int ST_RESET = 4;

	// ************************************************************
	// reset values and sizes
	// ************************************************************
	localparam logic [5:0] START_RST = 6'h00;
	localparam logic [5:0] COL_RST = 6'h00;
	localparam logic [2:0] PAGE_RST = 3'h0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [5:0] ROWS_FULL_LAST = 6'h3F;
	localparam logic [5:0] ROWS_HALF_LAST = 6'h1F;
	localparam logic [5:0] COL_LAST = 6'h3F;
	localparam int RAM_DEPTH = 512;

	typedef enum logic [1:0]
	{
		LCDD_ST_INIT = 2'b00,
		LCDD_ST_IDLE = 2'b01,
		LCDD_ST_BUSY = 2'b10
	} lcdd_state_e;

	typedef struct packed
	{
		logic [5:0] row;
		logic [5:0] col;
		logic dot;
	} lcdd_scan_s;

	// byte index of a page and column in display RAM
	function automatic logic [8:0] lcdd_ram_index(input logic [2:0] page, input logic [5:0] col);
		lcdd_ram_index = {page, col};
	endfunction : lcdd_ram_index

endpackage : lcdd_pkg

// ==== rtl/lcdd_decoder.sv ====
`timescale 1ns/10ps
module lcdd_decoder
	import lcdd_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// avalon-mm slave
	input wire logic [1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// device pins
	input wire logic reset_n_pin,
	input wire logic chip_select_a,
	input wire logic chip_select_b,
	input wire logic duty_half,
	// panel side
	output logic panel_on,
	output lcdd_scan_s scan
);

	// ************************************************************
	// bus handshake
	// ************************************************************
	logic [31:0] next_readdata;
	logic next_waitrequest;
	logic take;
	logic sel;
	logic ready;
	logic acc_wr_cmd;
	logic acc_wr_data;
	logic acc_rd_data;
	logic [7:0] wbyte;
	logic [7:0] status_byte;
	logic [7:0] host_byte;
	logic [7:0] scan_byte;

	lcdd_state_e state;
	lcdd_state_e next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic display_on;
	logic next_display_on;
	logic [5:0] start_line;
	logic [5:0] next_start_line;
	logic [2:0] page;
	logic [2:0] next_page;
	logic [5:0] col;
	logic [5:0] next_col;
	logic [7:0] out_reg;
	logic [7:0] next_out_reg;

	assign take = (avs_read | avs_write) & ~avs_waitrequest;
	assign sel = chip_select_a & chip_select_b;
	assign ready = (state == LCDD_ST_IDLE) & reset_n_pin;
	assign wbyte = avs_writedata[7:0];
	assign acc_wr_cmd = take & avs_write & sel & ready & (avs_address == ADDR_CMD);
	assign acc_wr_data = take & avs_write & sel & ready & (avs_address == ADDR_DATA);
	assign acc_rd_data = take & avs_read & sel & ready & (avs_address == ADDR_DATA);

	always_comb
	begin
		status_byte = BYTE_ZERO;
		status_byte[ST_BUSY] = (state != LCDD_ST_IDLE);
		status_byte[ST_ONOFF] = display_on;
		status_byte[ST_RESET] = (state == LCDD_ST_INIT) | ~reset_n_pin;
	end

	always_comb
	begin
		next_waitrequest = ~((avs_read | avs_write) & avs_waitrequest);
		next_readdata = avs_readdata;
		if (avs_read & avs_waitrequest)
		begin
			next_readdata = 32'h0000_0000;
			if (sel & (avs_address == ADDR_CMD))
			begin
				next_readdata[7:0] = status_byte;
			end
			else if (sel & ready & (avs_address == ADDR_DATA))
			begin
				next_readdata[7:0] = out_reg;
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end
		else
		begin
			avs_waitrequest <= next_waitrequest;
			avs_readdata <= next_readdata;
		end
	end

	// ************************************************************
	// operation sequencer
	// ************************************************************
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		// held in init while pin low
		if (!reset_n_pin)
		begin
			next_state = LCDD_ST_INIT;
			next_cnt = INIT_CNT;
		end
		else
		begin
			unique case (state)
				LCDD_ST_INIT:
				begin
					next_cnt = cnt - CNT_LAST;
					if (cnt == CNT_LAST)
					begin
						next_state = LCDD_ST_IDLE;
					end
				end
				LCDD_ST_IDLE:
				begin
					if (acc_wr_cmd | acc_wr_data | acc_rd_data)
					begin
						next_state = LCDD_ST_BUSY;
						next_cnt = BUSY_CNT;
					end
				end
				LCDD_ST_BUSY:
				begin
					next_cnt = cnt - CNT_LAST;
					if (cnt == CNT_LAST)
					begin
						next_state = LCDD_ST_IDLE;
					end
				end
				default:
				begin
					next_state = LCDD_ST_INIT;
					next_cnt = INIT_CNT;
				end
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			state <= LCDD_ST_INIT;
			cnt <= INIT_CNT;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	// ************************************************************
	// instruction registers
	// ************************************************************
	always_comb
	begin
		next_display_on = display_on;
		next_start_line = start_line;
		next_page = page;
		next_col = col;
		next_out_reg = out_reg;
		if (acc_wr_cmd)
		begin
			if (wbyte[7:1] == OP_ONOFF)
			begin
				next_display_on = wbyte[0];
			end
			else if (wbyte[7:3] == OP_PAGE)
			begin
				next_page = wbyte[2:0];
			end
			else if (wbyte[7:6] == OP_COL)
			begin
				next_col = wbyte[5:0];
			end
			else if (wbyte[7:6] == OP_START)
			begin
				next_start_line = wbyte[5:0];
			end
		end
		if (acc_wr_data)
		begin
			next_col = col + 6'h01;
		end
		if (acc_rd_data)
		begin
			next_out_reg = host_byte;
			next_col = col + 6'h01;
		end
		// reset pin blanks and clears start line
		if (!reset_n_pin)
		begin
			next_display_on = 1'b0;
			next_start_line = START_RST;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			display_on <= 1'b0;
			start_line <= START_RST;
			page <= PAGE_RST;
			col <= COL_RST;
			out_reg <= BYTE_ZERO;
		end
		else
		begin
			display_on <= next_display_on;
			start_line <= next_start_line;
			page <= next_page;
			col <= next_col;
			out_reg <= next_out_reg;
		end
	end

	// ************************************************************
	// display scan
	// ************************************************************
	logic [1:0] div;
	logic [1:0] next_div;
	logic [5:0] row;
	logic [5:0] next_row;
	logic [5:0] scol;
	logic [5:0] next_scol;
	logic [5:0] line;
	lcdd_scan_s next_scan;
	logic next_panel_on;

	assign line = start_line + row;

	always_comb
	begin
		next_div = div + 2'h1;
		next_row = row;
		next_scol = scol;
		if (div == SCAN_DIV_LAST)
		begin
			next_scol = scol + 6'h01;
			if (scol == COL_LAST)
			begin
				next_row = row + 6'h01;
				if (row == (duty_half ? ROWS_HALF_LAST : ROWS_FULL_LAST))
				begin
					next_row = 6'h00;
				end
			end
		end
		next_scan.row = row;
		next_scan.col = scol;
		// dot from RAM bit, gated by display flag
		next_scan.dot = display_on & scan_byte[line[2:0]];
		next_panel_on = display_on;
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			div <= 2'h0;
			row <= 6'h00;
			scol <= 6'h00;
			scan <= '0;
			panel_on <= 1'b0;
		end
		else
		begin
			div <= next_div;
			row <= next_row;
			scol <= next_scol;
			scan <= next_scan;
			panel_on <= next_panel_on;
		end
	end

	// RAM reached at current page and column
	lcdd_ram u_ram
	(
		.mclk(mclk),
		.wr_en(acc_wr_data),
		.host_idx(lcdd_ram_index(page, col)),
		.wr_byte(wbyte),
		.host_byte(host_byte),
		.scan_idx(lcdd_ram_index(line[5:3], scol)),
		.scan_byte(scan_byte)
	);

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	onoff_set_a: assert property (acc_wr_cmd && wbyte == 8'h3F && reset_n_pin |=> display_on)
		else $error("display not turned on");
	keep_ram_a: assert property (acc_wr_cmd |=> $stable(host_byte) || $changed(page) || $changed(col))
		else $error("instruction altered display RAM");
	col_load_a: assert property (acc_wr_cmd && wbyte[7:6] == OP_COL |=> col == $past(wbyte[5:0]))
		else $error("column not loaded");
	col_inc_a: assert property (acc_wr_data || acc_rd_data |=> col == 6'($past(col) + 6'h01))
		else $error("column not advanced");
	page_hold_a: assert property (!(acc_wr_cmd && wbyte[7:3] == OP_PAGE) |=> page == $past(page))
		else $error("page changed without page set");
	start_load_a: assert property (acc_wr_cmd && wbyte[7:6] == OP_START && reset_n_pin
		|=> start_line == $past(wbyte[5:0]))
		else $error("start line not latched");
	busy_time_a: assert property (acc_wr_cmd && reset_n_pin ##1 reset_n_pin [*5]
		|-> $past(state) == LCDD_ST_BUSY && state == LCDD_ST_IDLE)
		else $error("busy time wrong");
	init_ignore_a: assert property (state == LCDD_ST_INIT && reset_n_pin && take |=> $stable(col) && $stable(page)
		&& $stable(display_on) && $stable(start_line) && $stable(out_reg))
		else $error("access served during init");
	dummy_read_a: assert property (acc_rd_data |=> out_reg == $past(host_byte))
		else $error("read latch wrong");
	pin_reset_a: assert property (!reset_n_pin |=> !display_on && start_line == START_RST)
		else $error("reset pin did not blank");
	chip_sel_a: assert property (take && !sel |=> $stable(col) && $stable(page) && $stable(display_on))
		else $error("access without chip selects");
	status_zero_a: assert property (!avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h000000
		&& (avs_address != ADDR_CMD || (avs_readdata[6] == 1'b0 && avs_readdata[3:0] == 4'h0)))
		else $error("status reserved bits not zero");

endmodule : lcdd_decoder

// ==== rtl/lcdd_ram.sv ====
`timescale 1ns/10ps
module lcdd_ram
	import lcdd_pkg::*;
(
	// clock
	input wire logic mclk,
	// host port
	input wire logic wr_en,
	input wire logic [8:0] host_idx,
	input wire logic [7:0] wr_byte,
	output logic [7:0] host_byte,
	// scan port
	input wire logic [8:0] scan_idx,
	output logic [7:0] scan_byte
);

	// ************************************************************
	// display RAM, no reset so blanking never alters it
	// ************************************************************
	logic [7:0] mem [RAM_DEPTH];
	logic [7:0] next_mem [RAM_DEPTH];

	always_comb
	begin
		next_mem = mem;
		if (wr_en)
		begin
			next_mem[host_idx] = wr_byte;
		end
	end

	always_ff @(posedge mclk)
	begin
		mem <= next_mem;
	end

	assign host_byte = mem[host_idx];
	assign scan_byte = mem[scan_idx];

endmodule : lcdd_ram
